// [src/csf_pkg.sv]
package csf_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int REG_ADDR_W = 4;
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_PC_LO = 4'h1;
    localparam logic [3:0] OFF_PC_HI = 4'h2;
    localparam logic [3:0] OFF_CFG = 4'h3;

    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int BIT_RSV_INDIRECT = 7;
    localparam int BIT_RSV_BANK_HI = 6;
    localparam int BIT_BANK_SELECT = 5;
    localparam int BIT_WATCHDOG_EXPIRY = 4;
    localparam int BIT_POWERDOWN = 3;
    localparam int BIT_ZERO = 2;
    localparam int BIT_NIBBLE_CARRY = 1;
    localparam int BIT_CARRY = 0;
    localparam int NIBBLE_W = 4;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam int CFG_BIT_SMALL = 0;

    // ------------------------------------------------------------
    // program address map
    // ------------------------------------------------------------
    localparam int PC_W = 13;
    localparam logic [12:0] VEC_RESET = 13'h0000;
    localparam logic [12:0] VEC_IRQ = 13'h0004;
    localparam logic [12:0] MASK_2K = 13'h07FF;
    localparam logic [12:0] MASK_1K = 13'h03FF;

    // ------------------------------------------------------------
    // operations and carriers
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ADD = 4'h1,
        OP_SUB = 4'h2,
        OP_AND = 4'h3,
        OP_IOR = 4'h4,
        OP_XOR = 4'h5,
        OP_ROTL = 4'h6,
        OP_ROTR = 4'h7,
        OP_CLR = 4'h8,
        OP_MOVW = 4'h9,
        OP_MOVF = 4'hA,
        OP_SWAP = 4'hB,
        OP_BITCLR = 4'hC,
        OP_BITSET = 4'hD,
        OP_INC = 4'hE,
        OP_COM = 4'hF
    } csf_op_e;

    typedef struct packed {
        logic valid;
        csf_op_e op;
        logic [2:0] bitSel;
        logic [7:0] wVal;
        logic [7:0] fileVal;
        logic destFile;
        logic toStatus;
    } csf_exec_s;

    typedef struct packed {
        logic dogExpire;
        logic dogClear;
        logic sleepExec;
    } csf_evt_s;

    typedef struct packed {
        logic advance;
        logic jump;
        logic [12:0] jumpAddr;
        logic irqAccept;
    } csf_pc_s;

    typedef struct packed {
        logic [7:0] result;
        logic zOut;
        logic nibOut;
        logic cOut;
        logic affZ;
        logic affNib;
        logic affC;
    } csf_alu_s;

endpackage

// [src/csf_flag_alu.sv]
`timescale 1ns/100ps
module csf_flag_alu import csf_pkg::*; (
    input wire csf_op_e op,
    input wire logic [2:0] bitSel,
    input wire logic [7:0] wVal,
    input wire logic [7:0] fVal,
    input wire logic carryIn,
    output csf_alu_s aluOut
);

    logic [8:0] sum9;
    logic [4:0] nib5;

    // ------------------------------------------------------------
    // adder shared by add and subtract
    // ------------------------------------------------------------
    always_comb begin
        if (op == OP_SUB) begin
            sum9 = {1'b0, fVal} + {1'b0, ~wVal} + 9'h001;
            nib5 = {1'b0, fVal[3:0]} + {1'b0, ~wVal[3:0]} + 5'h01;
        end else begin
            sum9 = {1'b0, fVal} + {1'b0, wVal};
            nib5 = {1'b0, fVal[3:0]} + {1'b0, wVal[3:0]};
        end
    end

    // ------------------------------------------------------------
    // result and flag outputs
    // ------------------------------------------------------------
    always_comb begin
        aluOut = '0;
        case (op)
            OP_ADD, OP_SUB: begin
                aluOut.result = sum9[7:0];
                aluOut.cOut = sum9[8];
                aluOut.nibOut = nib5[NIBBLE_W];
                aluOut.affZ = 1'b1;
                aluOut.affNib = 1'b1;
                aluOut.affC = 1'b1;
            end
            OP_AND: begin
                aluOut.result = wVal & fVal;
                aluOut.affZ = 1'b1;
            end
            OP_IOR: begin
                aluOut.result = wVal | fVal;
                aluOut.affZ = 1'b1;
            end
            OP_XOR: begin
                aluOut.result = wVal ^ fVal;
                aluOut.affZ = 1'b1;
            end
            OP_ROTL: begin
                aluOut.result = {fVal[6:0], carryIn};
                aluOut.cOut = fVal[7];
                aluOut.affC = 1'b1;
            end
            OP_ROTR: begin
                aluOut.result = {carryIn, fVal[7:1]};
                aluOut.cOut = fVal[0];
                aluOut.affC = 1'b1;
            end
            OP_CLR: begin
                aluOut.result = 8'h00;
                aluOut.affZ = 1'b1;
            end
            OP_MOVW: begin
                aluOut.result = wVal;
            end
            OP_MOVF: begin
                aluOut.result = fVal;
                aluOut.affZ = 1'b1;
            end
            OP_SWAP: begin
                aluOut.result = {fVal[3:0], fVal[7:4]};
            end
            OP_BITCLR: begin
                aluOut.result = fVal & ~(8'h01 << bitSel);
            end
            OP_BITSET: begin
                aluOut.result = fVal | (8'h01 << bitSel);
            end
            OP_INC: begin
                aluOut.result = fVal + 8'h01;
                aluOut.affZ = 1'b1;
            end
            OP_COM: begin
                aluOut.result = ~fVal;
                aluOut.affZ = 1'b1;
            end
            default: begin
                aluOut.result = fVal;
            end
        endcase
        aluOut.zOut = (aluOut.result == 8'h00);
    end

endmodule

// [src/csf_core_status.sv]
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
// Behaviour
// - thirteen-bit program counter, 8K word space
// - fetch addresses wrap into 2K or 1K
// - reset fetches 0000h, interrupt vectors 0004h
// - flag-updating ops discard written flag bits
// - writes never change expiry or powerdown bits
// - clearing status gives 000u u1uu
// - bit 5 selects data bank
// - expiry bit set by powerup/clear/sleep, cleared timeout
// - powerdown bit set powerup/clear, cleared by sleep
// - zero bit follows zero result
// - nibble carry from bit 3, inverted borrow
// - carry from bit 7, inverted borrow
// - subtract adds two's complement
// - rotates load carry with shifted-out bit
module csf_core_status import csf_pkg::*; #(
    parameter logic SMALL_VARIANT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire csf_exec_s exec,
    input wire csf_evt_s evt,
    input wire csf_pc_s pcCtl,
    input wire logic [6:0] directAddr,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    output logic [7:0] resultData,
    output logic resultValid,
    output logic [PC_W-1:0] fetchAddr,
    output logic [7:0] dataAddr,
    output logic [7:0] statusOut
);

    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] cfg_reg;
    logic [PC_W-1:0] pc_reg;
    logic [PC_W-1:0] pc_next;
    logic [PC_W-1:0] fetch_reg;
    logic [PC_W-1:0] fetchMask;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] result_reg;
    logic resultValid_reg;
    logic [7:0] dataAddr_reg;
    logic [7:0] srcFile;
    logic anyAffected;
    logic statusDest;
    csf_alu_s aluOut;

    // ------------------------------------------------------------
    // operand select and flag datapath
    // ------------------------------------------------------------
    always_comb begin
        srcFile = exec.toStatus ? status_reg : exec.fileVal;
    end

    csf_flag_alu u_alu (
        .op(exec.op),
        .bitSel(exec.bitSel),
        .wVal(exec.wVal),
        .fVal(srcFile),
        .carryIn(status_reg[BIT_CARRY]),
        .aluOut(aluOut)
    );

    always_comb begin
        anyAffected = exec.valid & (aluOut.affZ | aluOut.affNib | aluOut.affC);
        statusDest = exec.valid & exec.destFile & exec.toStatus;
    end

    // ------------------------------------------------------------
    // status next value
    // ------------------------------------------------------------
    always_comb begin
        status_next = status_reg;
        if (regWr && (regAddr == OFF_STATUS)) begin
            status_next[BIT_RSV_INDIRECT] = regWdata[BIT_RSV_INDIRECT];
            status_next[BIT_RSV_BANK_HI] = regWdata[BIT_RSV_BANK_HI];
            status_next[BIT_BANK_SELECT] = regWdata[BIT_BANK_SELECT];
            status_next[BIT_ZERO] = regWdata[BIT_ZERO];
            status_next[BIT_NIBBLE_CARRY] = regWdata[BIT_NIBBLE_CARRY];
            status_next[BIT_CARRY] = regWdata[BIT_CARRY];
        end
        if (statusDest) begin
            status_next[BIT_RSV_INDIRECT] = aluOut.result[BIT_RSV_INDIRECT];
            status_next[BIT_RSV_BANK_HI] = aluOut.result[BIT_RSV_BANK_HI];
            status_next[BIT_BANK_SELECT] = aluOut.result[BIT_BANK_SELECT];
            if (!anyAffected) begin
                status_next[BIT_ZERO] = aluOut.result[BIT_ZERO];
                status_next[BIT_NIBBLE_CARRY] = aluOut.result[BIT_NIBBLE_CARRY];
                status_next[BIT_CARRY] = aluOut.result[BIT_CARRY];
            end
        end
        if (exec.valid && aluOut.affZ) begin
            status_next[BIT_ZERO] = aluOut.zOut;
        end
        if (exec.valid && aluOut.affNib) begin
            status_next[BIT_NIBBLE_CARRY] = aluOut.nibOut;
        end
        if (exec.valid && aluOut.affC) begin
            status_next[BIT_CARRY] = aluOut.cOut;
        end
        if (evt.dogClear || evt.sleepExec) begin
            status_next[BIT_WATCHDOG_EXPIRY] = 1'b1;
        end
        if (evt.dogExpire) begin
            status_next[BIT_WATCHDOG_EXPIRY] = 1'b0;
        end
        if (evt.dogClear) begin
            status_next[BIT_POWERDOWN] = 1'b1;
        end
        if (evt.sleepExec) begin
            status_next[BIT_POWERDOWN] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            status_reg <= STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cfg_reg <= CFG_RST | {7'h00, SMALL_VARIANT};
        end else if (regWr && (regAddr == OFF_CFG)) begin
            cfg_reg <= {7'h00, regWdata[CFG_BIT_SMALL]};
        end
    end

    // ------------------------------------------------------------
    // program counter and fetch address
    // ------------------------------------------------------------
    always_comb begin
        fetchMask = cfg_reg[CFG_BIT_SMALL] ? MASK_1K : MASK_2K;
        pc_next = pc_reg;
        if (pcCtl.irqAccept) begin
            pc_next = VEC_IRQ;
        end else if (pcCtl.jump) begin
            pc_next = pcCtl.jumpAddr;
        end else if (pcCtl.advance) begin
            pc_next = pc_reg + 13'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pc_reg <= VEC_RESET;
        end else begin
            pc_reg <= pc_next;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fetch_reg <= VEC_RESET;
        end else begin
            fetch_reg <= pc_next & fetchMask;
        end
    end

    // ------------------------------------------------------------
    // data bank mapping
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dataAddr_reg <= 8'h00;
        end else begin
            dataAddr_reg <= {status_next[BIT_BANK_SELECT], directAddr};
        end
    end

    // ------------------------------------------------------------
    // result register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            result_reg <= 8'h00;
            resultValid_reg <= 1'b0;
        end else begin
            resultValid_reg <= exec.valid;
            if (exec.valid) begin
                result_reg <= aluOut.result;
            end
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (regRd) begin
            if (regAddr == OFF_STATUS) begin
                rdata_next = status_reg;
            end else if (regAddr == OFF_PC_LO) begin
                rdata_next = pc_reg[7:0];
            end else if (regAddr == OFF_PC_HI) begin
                rdata_next = {3'h0, pc_reg[PC_W-1:8]};
            end else if (regAddr == OFF_CFG) begin
                rdata_next = cfg_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign regRdata = rdata_reg;
    assign resultData = result_reg;
    assign resultValid = resultValid_reg;
    assign fetchAddr = fetch_reg;
    assign dataAddr = dataAddr_reg;
    assign statusOut = status_reg;

endmodule

// [dv/csf_core_status_chk.sv]
`timescale 1ns/100ps
module csf_core_status_chk import csf_pkg::*; #(
    parameter logic SMALL_VARIANT = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire csf_exec_s exec,
    input wire csf_evt_s evt,
    input wire csf_pc_s pcCtl,
    input wire logic [6:0] directAddr,
    input wire logic [REG_ADDR_W-1:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] resultData,
    input wire logic resultValid,
    input wire logic [PC_W-1:0] fetchAddr,
    input wire logic [7:0] dataAddr,
    input wire logic [7:0] statusOut
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic quiet;
    assign quiet = !evt.dogExpire && !evt.dogClear && !evt.sleepExec;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_reset_vector: assert property ($rose(rstn) |-> fetchAddr == VEC_RESET && statusOut == STATUS_RST)
        else $error("reset state wrong");
    a_irq_vector: assert property (pcCtl.irqAccept |=> fetchAddr == VEC_IRQ)
        else $error("interrupt vector wrong");
    a_fetch_wrap: assert property ((fetchAddr & ~MASK_2K) == 13'h0000)
        else $error("fetch above implemented space");
    a_jump_masked: assert property (pcCtl.jump && !pcCtl.irqAccept |=>
        fetchAddr == ($past(pcCtl.jumpAddr) & MASK_2K) || fetchAddr == ($past(pcCtl.jumpAddr) & MASK_1K))
        else $error("jump address not wrapped");
    a_expire_clears: assert property (evt.dogExpire |=> !statusOut[BIT_WATCHDOG_EXPIRY])
        else $error("expiry bit not cleared");
    a_clear_sets: assert property (evt.dogClear && !evt.dogExpire && !evt.sleepExec |=> statusOut[4:3] == 2'b11)
        else $error("watchdog clear wrong");
    a_sleep_clears: assert property (evt.sleepExec && !evt.dogClear && !evt.dogExpire |=> statusOut[4:3] == 2'b10)
        else $error("sleep flags wrong");
    a_events_only: assert property (quiet |=> $stable(statusOut[4:3]))
        else $error("expiry or powerdown moved without event");
    a_clr_pattern: assert property (exec.valid && exec.op == OP_CLR && exec.destFile && exec.toStatus
        && quiet && !regWr |=> statusOut == {3'b000, $past(statusOut[4:3]), 1'b1, $past(statusOut[1:0])})
        else $error("clear of status wrong");
    a_bank_addr: assert property ($past(rstn) |-> dataAddr == {statusOut[BIT_BANK_SELECT], $past(directAddr)})
        else $error("bank select not applied");
    a_add_carry: assert property (exec.valid && exec.op == OP_ADD && !exec.toStatus
        |=> {statusOut[BIT_CARRY], resultData} == ({1'b0, $past(exec.fileVal)} + {1'b0, $past(exec.wVal)}))
        else $error("add carry wrong");
    c_irq: cover property (pcCtl.irqAccept);
    c_to_status: cover property (exec.valid && exec.toStatus && exec.destFile);
    c_expire_clear: cover property (evt.dogExpire && evt.dogClear);
endmodule
bind csf_core_status csf_core_status_chk #(.SMALL_VARIANT(SMALL_VARIANT)) i_chk (.ref_clk(ref_clk), .rstn(rstn),
    .exec(exec), .evt(evt), .pcCtl(pcCtl), .directAddr(directAddr), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .resultData(resultData), .resultValid(resultValid),
    .fetchAddr(fetchAddr), .dataAddr(dataAddr), .statusOut(statusOut));

// [dv/csf_tb.sv]
`timescale 1ns/100ps
module testbench import csf_pkg::*;;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    csf_exec_s exec;
    csf_evt_s evt;
    csf_pc_s pcCtl;
    logic [6:0] directAddr;
    logic [3:0] regAddr;
    logic [7:0] regWdata, regRdata, resultData, dataAddr, statusOut, expSt;
    logic regWr, regRd, resultValid;
    logic [12:0] fetchAddr, pcM, mask;
    int errTotal, testsRun;
    csf_op_e ops [15] = '{OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_ROTL, OP_ROTR, OP_CLR, OP_MOVW, OP_MOVF,
        OP_SWAP, OP_BITCLR, OP_BITSET, OP_INC, OP_COM};
    logic [2:0] evts [5] = '{3'b100, 3'b001, 3'b010, 3'b110, 3'b101};
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    csf_core_status i_dut (.ref_clk(ref_clk), .rstn(rstn), .exec(exec), .evt(evt), .pcCtl(pcCtl),
        .directAddr(directAddr), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .resultData(resultData), .resultValid(resultValid), .fetchAddr(fetchAddr),
        .dataAddr(dataAddr), .statusOut(statusOut));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [12:0] e, logic [12:0] g);
        testsRun++;
        if (g !== e) begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic do_reset(int n);
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (n) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        expSt = STATUS_RST;
        pcM = VEC_RESET;
        mask = MASK_2K;
        chk("status", 13'(expSt), 13'(statusOut));
        chk("fetchAddr", VEC_RESET, fetchAddr);
        chk("resultValid", 13'h0000, 13'(resultValid));
    endtask
    task automatic reg_wr(logic [3:0] a, logic [7:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        directAddr <= 7'($urandom);
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
        if (a == OFF_STATUS) expSt = {d[7:5], expSt[4:3], d[2:0]};
        if (a == OFF_CFG) mask = d[0] ? MASK_1K : MASK_2K;
        chk("status", 13'(expSt), 13'(statusOut));
        chk("dataAddr", 13'({expSt[5], directAddr}), 13'(dataAddr));
    endtask
    task automatic reg_rd(logic [3:0] a, logic [7:0] e);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk("regRdata", 13'(e), 13'(regRdata));
        @(posedge ref_clk);
        #1;
        chk("regRdata idle", 13'h0000, 13'(regRdata));
    endtask
    function automatic logic [13:0] alu_model(csf_op_e op, logic [7:0] w, logic [7:0] f, logic ci);
        logic [8:0] s;
        logic [4:0] n;
        logic [2:0] aff;
        s = {1'b0, f} + {1'b0, w};
        n = {1'b0, f[3:0]} + {1'b0, w[3:0]};
        aff = 3'b100;
        case (op)
            OP_ADD: aff = 3'b111;
            OP_SUB: begin
                s = {1'b0, f} + {1'b0, ~w} + 9'h001;
                n = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
                aff = 3'b111;
            end
            OP_AND: s[7:0] = f & w;
            OP_IOR: s[7:0] = f | w;
            OP_XOR: s[7:0] = f ^ w;
            OP_ROTL: begin
                s = {f, ci};
                aff = 3'b001;
            end
            OP_ROTR: begin
                s = {f[0], ci, f[7:1]};
                aff = 3'b001;
            end
            OP_CLR: s[7:0] = 8'h00;
            OP_MOVF: s[7:0] = f;
            OP_INC: s[7:0] = f + 8'h01;
            OP_COM: s[7:0] = ~f;
            OP_SWAP: begin
                s[7:0] = {f[3:0], f[7:4]};
                aff = 3'b000;
            end
            OP_BITCLR: begin
                s[7:0] = f & ~(8'h01 << w[2:0]);
                aff = 3'b000;
            end
            OP_BITSET: begin
                s[7:0] = f | (8'h01 << w[2:0]);
                aff = 3'b000;
            end
            default: begin
                s[7:0] = w;
                aff = 3'b000;
            end
        endcase
        return {aff, s[7:0] == 8'h00, n[4], s[8], s[7:0]};
    endfunction
    task automatic run_op(csf_op_e op, logic [7:0] w, logic [7:0] f, logic d, logic ts);
        logic [13:0] m;
        m = alu_model(op, w, ts ? expSt : f, expSt[0]);
        @(posedge ref_clk);
        exec <= '{1'b1, op, w[2:0], w, f, d, ts};
        @(posedge ref_clk);
        exec.valid <= 1'b0;
        #1;
        if (ts && d) expSt = {m[7:5], expSt[4:3], (m[13:11] != 3'b000) ? expSt[2:0] : m[2:0]};
        if (m[13]) expSt[2] = m[10];
        if (m[12]) expSt[1] = m[9];
        if (m[11]) expSt[0] = m[8];
        chk("resultData", 13'(m[7:0]), 13'(resultData));
        chk("status", 13'(expSt), 13'(statusOut));
        chk("resultValid", 13'h0001, 13'(resultValid));
    endtask
    task automatic evt_pulse(logic [2:0] e);
        @(posedge ref_clk);
        evt <= e;
        @(posedge ref_clk);
        evt <= 3'b000;
        #1;
        if (e[1]) expSt[4:3] = 2'b11;
        if (e[0]) expSt[4:3] = 2'b10;
        if (e[2]) expSt[4] = 1'b0;
        chk("status", 13'(expSt), 13'(statusOut));
    endtask
    task automatic pc_step(logic adv, logic jmp, logic irq, logic [12:0] a);
        @(posedge ref_clk);
        pcCtl <= '{adv, jmp, a, irq};
        @(posedge ref_clk);
        pcCtl <= '0;
        #1;
        pcM = irq ? VEC_IRQ : jmp ? a : adv ? pcM + 13'h0001 : pcM;
        chk("fetchAddr", pcM & mask, fetchAddr);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        exec = '0;
        evt = '0;
        pcCtl = '0;
        directAddr = 7'h00;
        regAddr = 4'h0;
        regWdata = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        errTotal = 0;
        testsRun = 0;
        void'($urandom(32'hFEA5));
        do_reset(5);
        reg_rd(OFF_STATUS, STATUS_RST);
        reg_rd(OFF_CFG, CFG_RST);
        reg_rd(4'h7, 8'h00);
        reg_wr(OFF_STATUS, 8'h27);
        foreach (evts[i]) begin
            evt_pulse(evts[i]);
            reg_wr(OFF_STATUS, 8'($urandom) & 8'h3F);
        end
        run_op(OP_ADD, 8'h01, 8'hFF, 1'b0, 1'b0);
        run_op(OP_SUB, 8'h35, 8'h35, 1'b0, 1'b0);
        run_op(OP_SUB, 8'h01, 8'h00, 1'b0, 1'b0);
        run_op(OP_ROTL, 8'h00, 8'h80, 1'b0, 1'b0);
        run_op(OP_ROTR, 8'h00, 8'h01, 1'b0, 1'b0);
        run_op(OP_CLR, 8'h00, 8'h00, 1'b1, 1'b1);
        run_op(OP_MOVW, 8'h27, 8'h00, 1'b1, 1'b1);
        run_op(OP_ADD, 8'h09, 8'h00, 1'b1, 1'b1);
        run_op(OP_BITCLR, 8'h05, 8'h00, 1'b1, 1'b1);
        run_op(OP_BITSET, 8'h05, 8'h00, 1'b1, 1'b1);
        repeat (60) run_op(ops[$urandom_range(14)], 8'($urandom), 8'($urandom), 1'b0, 1'($urandom));
        pc_step(1'b0, 1'b0, 1'b1, 13'h0000);
        pc_step(1'b1, 1'b0, 1'b0, 13'h0000);
        pc_step(1'b1, 1'b1, 1'b1, 13'h1ABC);
        pc_step(1'b0, 1'b1, 1'b0, 13'h1FFF);
        reg_rd(OFF_PC_LO, 8'hFF);
        reg_rd(OFF_PC_HI, 8'h1F);
        pc_step(1'b1, 1'b0, 1'b0, 13'h0000);
        reg_wr(OFF_CFG, 8'h01);
        repeat (6) pc_step(1'($urandom), 1'b1, 1'b0, 13'($urandom));
        evt_pulse(3'b100);
        do_reset(2);
        tally_and_finish();
    end
    initial begin
        #50000;
        errTotal++;
        tally_and_finish();
    end
endmodule
